/* File: core/supply_watchdog_reset_monitor.sv */
// supervisory reset: supply monitor stretch, pushbutton, watchdog
// assumes one 100 MHz clock; the comparator is an outside logic input
// What this block does
// - debounce active-low pushbutton, ignore short pulses
// - assert reset only after pushbutton delay elapses
// - hold reset 250ms after pushbutton release
// - timeout select picks 150, 600, 1200ms
// - tolerance select picks 5% or 10% threshold
// - reset active while supply below threshold
// - release after 250ms continuous good supply
// - only falling strobe edges restart watchdog
// - missed strobe gives 250ms reset pulse
// - repeat pulses each period until strobed
// - push-pull high and open-drain low outputs
`default_nettype none

module supply_watchdog_reset_monitor
    import supervisor_pkg::*;
#(
    parameter int TICK_CYCLES_P = supervisor_pkg::TICK_CYCLES
) (
    input wire logic ref_clk_i,           // 100 MHz clock
    input wire logic rstn_i,              // sync reset, active low
    input wire logic manual_reset_n_i,    // pushbutton, active low
    input wire logic watchdog_kick_n_i,   // strobe from host
    input wire logic supply_low_i,        // comparator: supply bad
    input wire logic supply_margin_sel_i, // 0: 5%, 1: 10%
    input wire logic [1:0] timeout_select_i, // gnd/open/vcc code
    output logic margin_sel_o,            // threshold select to comparator
    output logic reset_out_high_o,        // reset, active high
    output logic reset_out_low_od_o,      // open drain level, always 0
    output logic reset_out_low_oe_o,      // open drain enable, high=pull low
    output logic [1:0] state_o            // run or hold, for observation
);
    cond_if cond ();

    input_conditioner #(
        .TICK_CYCLES_P(TICK_CYCLES_P)
    ) u_cond (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .kick_n_i(watchdog_kick_n_i),
        .manual_n_i(manual_reset_n_i),
        .supply_low_i(supply_low_i),
        .margin_sel_i(supply_margin_sel_i),
        .td_code_i(timeout_select_i),
        .cond(cond.src)
    );

    logic [PB_W-1:0] pb_cnt;
    logic pb_pressed;
    logic kick_prev;
    logic [MS_W-1:0] wd_cnt;
    logic [MS_W-1:0] hold_cnt;
    logic [1:0] td_q;
    sup_state_t state;
    sup_state_t next_state;

    // pushbutton debounce: needs PB_DELAY consecutive low ticks, and any
    // high sample restarts; pulses under 3ms never reach the four-tick count
    wire pb_low = !cond.manual_n;
    wire pb_at_delay = (pb_cnt == PB_DELAY);
    wire pb_step = pb_low && cond.ms_tick && !pb_at_delay;

    // debounce counter and pressed flag
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pb_cnt <= PB_ZERO;
            pb_pressed <= 1'b0;
        end else begin
            pb_cnt <= !pb_low ? PB_ZERO : (pb_step ? pb_cnt + PB_ONE : pb_cnt);
            pb_pressed <= pb_low && pb_at_delay;
        end
    end

    // timeout select latched from the synchronised strap; an undefined
    // code falls back to the longest period, the safer side
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            td_q <= TD_OPEN;
        end else begin
            td_q <= cond.td_code;
        end
    end

    // watchdog period decode
    wire [MS_W-1:0] wd_period = (td_q == TD_GND) ? WD_SHORT :
                                (td_q == TD_OPEN) ? WD_MEDIUM : WD_LONG;

    // strobe edge detect on the synchronised level
    wire kick_fall = kick_prev && !cond.kick_n;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            kick_prev <= 1'b1;
        end else begin
            kick_prev <= cond.kick_n;
        end
    end

    // watchdog expiry: period reached with no falling edge seen
    wire reset_now = (state == ST_HOLD);
    wire wd_expire = !reset_now && (wd_cnt >= wd_period) && !kick_fall;

    // watchdog counter; held at zero through any reset so the full period
    // runs again after release, which yields the repeated pulses
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wd_cnt <= MS_ZERO;
        end else if (reset_now || kick_fall) begin
            wd_cnt <= MS_ZERO;
        end else if (cond.ms_tick && !wd_expire) begin
            wd_cnt <= wd_cnt + MS_ONE;    // sets the host's pace
        end
    end

    // any live cause reloads the stretch; cause ending starts the 250ms
    wire cause = cond.supply_low || pb_pressed || wd_expire;
    wire hold_done = (hold_cnt == MS_ZERO);

    // stretch counter; a new undervoltage restarts the interval
    // power-up loads it so the first release also waits 250ms
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            hold_cnt <= HOLD_LOAD;
        end else if (cause) begin
            hold_cnt <= HOLD_LOAD;
        end else if (cond.ms_tick && !hold_done) begin
            hold_cnt <= hold_cnt - MS_ONE;
        end
    end

    // reset state: hold while a cause stands or the stretch runs
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (cause) begin
                    next_state = ST_HOLD;  // on any cause: supply low, button or expiry
                end
            end
            ST_HOLD: begin
                if (!cause && hold_done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // both outputs move together from one register stage
    wire next_reset = (next_state == ST_HOLD);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state <= ST_HOLD;
            reset_out_high_o <= 1'b1;
            reset_out_low_oe_o <= 1'b1;
            reset_out_low_od_o <= 1'b0;
            margin_sel_o <= 1'b0;
            state_o <= 2'h1;
        end else begin
            state <= next_state;
            reset_out_high_o <= next_reset;
            reset_out_low_oe_o <= next_reset;  // drives low only
            reset_out_low_od_o <= 1'b0;
            margin_sel_o <= cond.margin_sel;
            state_o <= 2'(next_state);
        end
    end
endmodule

`default_nettype wire

/* File: pkg/supervisor_pkg.sv */
// constants shared by the supervisory reset block and its input conditioner
// assumes a single 100 MHz clock and a millisecond timebase built from it
`default_nettype none

package supervisor_pkg;

    // clock and timebase
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMEBASE_NS = 1000000;
    localparam int TICK_CYCLES = TIMEBASE_NS / CLK_PERIOD_NS;

    // times in milliseconds, counted in timebase ticks
    localparam int RESET_ACTIVE_MS = 250;
    localparam int PB_DELAY_MS = 4;
    localparam int WD_SHORT_MS = 150;
    localparam int WD_MEDIUM_MS = 600;
    localparam int WD_LONG_MS = 1200;

    // width of the millisecond counters
    localparam int MS_W = 11;
    localparam int PB_W = 5;

    // tick counts; a tick may land just after a load, so the hold count adds one
    localparam logic [MS_W-1:0] HOLD_LOAD = MS_W'(RESET_ACTIVE_MS + 1);
    localparam logic [PB_W-1:0] PB_DELAY = PB_W'(PB_DELAY_MS);
    localparam logic [MS_W-1:0] WD_SHORT = MS_W'(WD_SHORT_MS);
    localparam logic [MS_W-1:0] WD_MEDIUM = MS_W'(WD_MEDIUM_MS);
    localparam logic [MS_W-1:0] WD_LONG = MS_W'(WD_LONG_MS);
    localparam logic [MS_W-1:0] MS_ZERO = '0;
    localparam logic [MS_W-1:0] MS_ONE = MS_W'(1);
    localparam logic [PB_W-1:0] PB_ZERO = '0;
    localparam logic [PB_W-1:0] PB_ONE = PB_W'(1);

    // three-state timeout select, seen as two level bits
    localparam logic [1:0] TD_GND = 2'h0;
    localparam logic [1:0] TD_OPEN = 2'h1;
    localparam logic [1:0] TD_VCC = 2'h2;

    // reset output state
    typedef enum logic [1:0] {ST_RUN, ST_HOLD} sup_state_t;

endpackage

`default_nettype wire

/* File: pkg/cond_if.sv */
// carrier between the input conditioner and the supervisory core
// assumes both ends run on the same clock
`default_nettype none

interface cond_if;
    logic ms_tick;
    logic kick_n;
    logic manual_n;
    logic supply_low;
    logic margin_sel;
    logic [1:0] td_code;

    modport src (output ms_tick, kick_n, manual_n, supply_low, margin_sel,
                 td_code);
    modport snk (input ms_tick, kick_n, manual_n, supply_low, margin_sel,
                 td_code);
endinterface

`default_nettype wire

/* File: core/input_conditioner.sv */
// two-flop synchronisers for all pin inputs and the millisecond divider
// assumes pins are asynchronous to ref_clk_i
`default_nettype none

module input_conditioner
    import supervisor_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic ref_clk_i,        // system clock
    input wire logic rstn_i,           // sync reset, active low
    input wire logic kick_n_i,         // raw strobe pin
    input wire logic manual_n_i,       // raw pushbutton pin
    input wire logic supply_low_i,     // raw comparator output
    input wire logic margin_sel_i,     // raw tolerance strap
    input wire logic [1:0] td_code_i,  // raw timeout select
    cond_if.src cond                   // conditioned signals
);
    localparam int N = 6;
    localparam int DIV_W = $clog2(TICK_CYCLES_P + 1);

    logic [N-1:0] raw;
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    wire div_wrap = (div_cnt == DIV_W'(TICK_CYCLES_P - 1));

    assign raw = {td_code_i, margin_sel_i, supply_low_i, manual_n_i,
                  kick_n_i};

    // two flops per pin; first stage feeds only the second
    // idle levels: strobe and button high, straps low, supply treated low until proven good
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            meta <= 6'h07;
            sync <= 6'h07;
        end else begin
            meta <= raw;
            sync <= meta;
        end
    end

    // millisecond enable pulse
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else begin
            div_cnt <= div_wrap ? '0 : div_cnt + DIV_W'(1);
            tick <= div_wrap;
        end
    end

    assign cond.ms_tick = tick;
    assign cond.kick_n = sync[0];
    assign cond.manual_n = sync[1];
    assign cond.supply_low = sync[2];
    assign cond.margin_sel = sync[3];
    assign cond.td_code = sync[5:4];
endmodule

`default_nettype wire

/* File: dv/host_cpu_model.sv */
// host processor model: strobes the watchdog kick line
// assumes the bench clock; kick falls each period, rises halfway
`default_nettype none

module host_cpu_model #(
    parameter int PERIOD = 1000
) (
    input wire logic clk_i, // bench clock
    input wire logic en_i,  // strobing allowed
    output logic kick_n_o   // kick line to the monitor
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;

    initial kick_n_o = 1'b1;

    // rising half has no meaning to the monitor, but keeps it honest
    always @(posedge clk_i) begin
        cnt <= (cnt + 1) % PERIOD;
        if (en_i && cnt == 0) begin
            kick_n_o <= 1'b0;
        end else if (cnt == PERIOD / 2) begin
            kick_n_o <= 1'b1;
        end
    end
endmodule

`default_nettype wire

/* File: dv/supply_watchdog_reset_monitor_checker.sv */
// assertions on the supervisory reset block's ports
// assumes the same millisecond length as the watched instance
`default_nettype none

module supply_watchdog_reset_monitor_checker #(
    parameter int TICK_CYCLES_P = 10
) (
    input wire logic ref_clk_i, // clock
    input wire logic rstn_i, // reset
    input wire logic manual_reset_n_i, // button
    input wire logic watchdog_kick_n_i, // strobe
    input wire logic supply_low_i, // supply bad
    input wire logic supply_margin_sel_i, // strap
    input wire logic [1:0] timeout_select_i, // period
    input wire logic margin_sel_o, // strap copy
    input wire logic reset_out_high_o, // reset
    input wire logic reset_out_low_od_o, // od level
    input wire logic reset_out_low_oe_o, // od enable
    input wire logic [1:0] state_o // state
);
    logic [31:0] low_cnt;

    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // consecutive low samples of the button, saturating
    always_ff @(posedge ref_clk_i) begin
        if (manual_reset_n_i) low_cnt <= '0;
        else if (low_cnt != 32'hffff_ffff) low_cnt <= low_cnt + 32'h1;
    end

    AST_OD_PAIR:
        assert property (reset_out_low_oe_o == reset_out_high_o
            && !reset_out_low_od_o) else $error("od pair wrong");
    AST_SUPPLY_ON:
        assert property (supply_low_i |-> ##[0:4] reset_out_high_o)
            else $error("no reset on low supply");
    AST_SUPPLY_STAY:
        assert property ($fell(supply_low_i) |-> ##2 reset_out_high_o[*8])
            else $error("supply reset dropped early");
    AST_PB_NOT_FIRST:
        assert property ($fell(manual_reset_n_i) && !reset_out_high_o
            |=> !reset_out_high_o[*8]) else $error("button too fast");
    AST_PB_LONG:
        assert property (low_cnt == 32'(20 * TICK_CYCLES_P)
            |-> reset_out_high_o) else $error("long press missed");
    AST_RELEASE:
        assert property ($fell(reset_out_high_o) |->
            $past(manual_reset_n_i, 4) && !$past(supply_low_i, 4))
            else $error("release while cause stands");
    AST_MARGIN:
        assert property ($stable(supply_margin_sel_i)[*5]
            |-> margin_sel_o == supply_margin_sel_i)
            else $error("margin not relayed");
    AST_PULSE:
        assert property ($rose(reset_out_high_o) |=> reset_out_high_o[*8])
            else $error("reset pulse too short");
endmodule

bind supply_watchdog_reset_monitor supply_watchdog_reset_monitor_checker
    #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_checker (.ref_clk_i, .rstn_i,
    .manual_reset_n_i, .watchdog_kick_n_i, .supply_low_i,
    .supply_margin_sel_i, .timeout_select_i, .margin_sel_o,
    .reset_out_high_o, .reset_out_low_od_o, .reset_out_low_oe_o, .state_o);

`default_nettype wire

/* File: dv/supply_watchdog_reset_monitor_tb.sv */
// testbench for the supervisory reset block
// assumes a 10-cycle millisecond so every time scales by ten
`default_nettype none

module supply_watchdog_reset_monitor_tb
    import supervisor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 10;
    logic ref_clk, rstn = 0, manual_n = 1, supply_low = 0, margin = 0;
    logic host_en = 0, kick_d = 1, margin_o, rst_hi, od, oe;
    logic [1:0] td = TD_GND;
    logic [1:0] state;
    wire logic kick_n;
    wire logic low_pin = oe ? od : 1'b1; // pulled up when released
    int bad_count = 0, samples_checked = 0, since_fall = 0, n;

    supply_watchdog_reset_monitor #(.TICK_CYCLES_P(MS))
        i_supply_watchdog_reset_monitor (.ref_clk_i(ref_clk),
        .rstn_i(rstn), .manual_reset_n_i(manual_n),
        .watchdog_kick_n_i(kick_n), .supply_low_i(supply_low),
        .supply_margin_sel_i(margin), .timeout_select_i(td),
        .margin_sel_o(margin_o), .reset_out_high_o(rst_hi),
        .reset_out_low_od_o(od), .reset_out_low_oe_o(oe), .state_o(state));
    host_cpu_model #(.PERIOD(100 * MS)) i_host_cpu_model (.clk_i(ref_clk),
        .en_i(host_en), .kick_n_o(kick_n));

    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end

    // cycles since the last falling kick
    always @(posedge ref_clk) begin
        kick_d <= kick_n;
        since_fall <= (kick_d && !kick_n) ? 0 : since_fall + 1;
    end

    task automatic check(string what, int lo, int hi, int seen);
        samples_checked++;
        if (seen < lo || seen > hi) begin
            bad_count++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi,
                seen);
        end
    endtask

    // counts cycles while reset holds a level, bounded
    task automatic span(logic lvl, int limit, output int c);
        c = 0;
        while (rst_hi === lvl && c < limit) begin
            @(negedge ref_clk);
            c++;
        end
    endtask

    task automatic test_supply();
        @(posedge ref_clk) supply_low <= 1'b1;
        margin <= 1'b1;
        repeat (100) @(negedge ref_clk);
        check("margin", 1, 1, margin_o === 1'b1);
        check("supply low", 1, 1, rst_hi === 1'b1);
        @(posedge ref_clk) supply_low <= 1'b0;
        repeat (1000) @(negedge ref_clk);
        check("stretch", 1, 1, rst_hi === 1'b1);
        @(posedge ref_clk) supply_low <= 1'b1;
        repeat (20) @(posedge ref_clk);
        supply_low <= 1'b0;
        span(1'b1, 3000, n);
        check("restart", 250 * MS, 252 * MS + 10, n);
    endtask

    task automatic test_button();
        @(posedge ref_clk) manual_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        manual_n <= 1'b1;
        span(1'b0, 100, n);
        check("short press", 100, 100, n);
        check("state run", 1, 1, state === 2'h0);
        @(posedge ref_clk) manual_n <= 1'b0;
        repeat (20 * MS) @(negedge ref_clk);
        check("long press", 1, 1, rst_hi === 1'b1);
        check("od pin", 1, 1, low_pin === 1'b0);
        check("state hold", 1, 1, state === 2'h1);
        @(posedge ref_clk) manual_n <= 1'b1;
        span(1'b1, 3000, n);
        check("press hold", 250 * MS, 252 * MS + 10, n);
    endtask

    // kicks hold reset off, then silence gives repeating pulses
    task automatic test_watchdog(logic [1:0] code, int per);
        @(posedge ref_clk) td <= code;
        host_en <= 1'b1;
        span(1'b1, 3000, n);
        span(1'b0, 300 * MS, n);
        check("kicked", 300 * MS, 300 * MS, n);
        @(posedge ref_clk) host_en <= 1'b0;
        span(1'b0, 3000 * MS, n);
        // the count starts on whatever tick phase the kick leaves it
        // in, so expiry may come up to one millisecond early
        check("expiry", per * MS - 10, per * MS + 40, since_fall);
        span(1'b1, 3000, n);
        check("pulse", 250 * MS, 252 * MS + 10, n);
        span(1'b0, 3000 * MS, n);
        check("repeat", per * MS - 20, per * MS + 40, n);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        host_en <= 1'b1;
        @(negedge ref_clk);
        span(1'b1, 3000, n);
        check("power-up", 250 * MS, 252 * MS + 10, n);
        test_supply();
        test_button();
        test_watchdog(TD_GND, WD_SHORT_MS);
        test_watchdog(TD_OPEN, WD_MEDIUM_MS);
        test_watchdog(TD_VCC, WD_LONG_MS);
        test_done();
    end

    // about 70k cycles of tests, so cut off at 100k
    initial begin
        #1000000;
        bad_count++;
        test_done();
    end
endmodule

`default_nettype wire
